// ===== logic/frws_pkg.sv
// Purpose: Shared constants for the fault, retry and watchdog supervisor
// Assumes: 20 MHz reference clock, one millisecond internal timebase
// Notes:   Every delay below is counted in timebase ticks or in clock cycles
package frws_pkg;

    // ----------------------------------------------------------------
    // Clock and timebase
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

    // ----------------------------------------------------------------
    // Fault timing in timebase ticks
    // ----------------------------------------------------------------
    localparam int unsigned OC_LIMIT_MS     = 10;
    localparam int unsigned RETRY_OFF_MS    = 100;
    localparam int unsigned RESET_EXTRA_MS  = 10;
    localparam logic [7:0]  OC_LIMIT_TICKS  = 8'(OC_LIMIT_MS / TICK_MS);
    localparam logic [7:0]  RETRY_TICKS     = 8'(RETRY_OFF_MS / TICK_MS);
    localparam logic [7:0]  RESET_TICKS     = 8'(RESET_EXTRA_MS / TICK_MS);

    // ----------------------------------------------------------------
    // Regulation deglitch in clock cycles, rounded up
    // ----------------------------------------------------------------
    localparam int unsigned DEGLITCH_NS     = 20_000;
    localparam logic [8:0]  DEGLITCH_CYCLES =
        9'((DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Switcher oscillator half periods in clock cycles
    // ----------------------------------------------------------------
    localparam logic [6:0]  OSC_HALF_DEF    = 7'd33;
    localparam logic [6:0]  OSC_HALF_MIN    = 7'd25;
    localparam logic [6:0]  OSC_HALF_MAX    = 7'd50;

    // ----------------------------------------------------------------
    // Register map, byte offsets on 32-bit words
    // ----------------------------------------------------------------
    localparam logic [3:0]  REG_WDOG_CMD    = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam int unsigned CMD_WINDOW_BIT  = 7;
    localparam int unsigned CMD_SEL_LSB     = 0;
    localparam int unsigned CMD_SEL_W       = 3;
    localparam logic [7:0]  CMD_RESET       = 8'h00;

    // ----------------------------------------------------------------
    // Enable decode and state encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FRWS_SEQ_OFF      = 2'b00,
        FRWS_SEQ_STANDARD = 2'b01,
        FRWS_SEQ_INVERTED = 2'b10,
        FRWS_SEQ_NONE     = 2'b11
    } frws_seq_t;

    typedef enum logic [1:0] {
        FRWS_RT_IDLE = 2'b00,
        FRWS_RT_RUN  = 2'b01,
        FRWS_RT_OFF  = 2'b10
    } frws_retry_t;

    typedef enum logic {
        FRWS_RS_HOLD     = 1'b0,
        FRWS_RS_RELEASED = 1'b1
    } frws_rst_t;

endpackage

// ===== logic/frws_retry_if.sv
// Purpose: Carries timebase, enable and fault into a retry unit and its state out
// Assumes: One clock domain
// Notes:   ctrl is the supervisor side, unit is the retry timer side
interface frws_retry_if;
    logic tick;
    logic en;
    logic oc;
    logic run;
    logic limited;
    logic soft_start;

    modport ctrl (output tick, output en, output oc,
                  input run, input limited, input soft_start);
    modport unit (input tick, input en, input oc,
                  output run, output limited, output soft_start);
endinterface

// ===== logic/frws_retry.sv
// Purpose: Over-current limit and retry timer for one regulator
// Assumes: tick is a one-cycle pulse once per timebase period
// Notes:   run, limited and soft_start all come from flip-flops
module frws_retry
    import frws_pkg::*;
(
    // Clock and reset
    input  wire logic   i_ref_clk,
    input  wire logic   i_rst_n,
    // Supervisor side
    frws_retry_if.unit  rif
);
    frws_retry_t state;
    frws_retry_t next_state;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic        next_start;

    wire logic oc_done  = rif.oc && rif.tick && (cnt + 8'd1 >= OC_LIMIT_TICKS);
    wire logic off_done = rif.tick && (cnt + 8'd1 >= RETRY_TICKS);

    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_start = 1'b0;
        case (state)
            FRWS_RT_IDLE:
            begin
                next_cnt = 8'h00;
                if (rif.en)
                begin
                    next_state = FRWS_RT_RUN;
                    next_start = 1'b1;
                end
            end
            FRWS_RT_RUN:
            begin
                if (!rif.oc)
                    next_cnt = 8'h00;
                else if (oc_done)
                begin
                    next_state = FRWS_RT_OFF;
                    next_cnt   = 8'h00;
                end
                else if (rif.tick)
                    next_cnt = cnt + 8'd1;
            end
            FRWS_RT_OFF:
            begin
                if (off_done)
                begin
                    next_state = FRWS_RT_RUN;
                    next_cnt   = 8'h00;
                    next_start = 1'b1;
                end
                else if (rif.tick)
                    next_cnt = cnt + 8'd1;
            end
            default:
            begin
                next_state = FRWS_RT_IDLE;
                next_cnt   = 8'h00;
            end
        endcase
        if (!rif.en)
        begin
            next_state = FRWS_RT_IDLE;
            next_cnt   = 8'h00;
            next_start = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state          <= FRWS_RT_IDLE;
            cnt            <= 8'h00;
            rif.run        <= 1'b0;
            rif.limited    <= 1'b0;
            rif.soft_start <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            cnt            <= next_cnt;
            rif.run        <= (next_state == FRWS_RT_RUN);
            rif.limited    <= (next_state == FRWS_RT_RUN) && rif.oc;
            rif.soft_start <= next_start;
        end
    end
endmodule

// ===== logic/frws_supervisor.sv
// Purpose: Fault retry, oscillator, watchdog and reset supervisor, Avalon-MM slave
// Assumes: All pin inputs synchronous to i_ref_clk
// Notes:   Watchdog commands arrive as writes to the command register
module frws_supervisor
    import frws_pkg::*;
#(
    parameter int unsigned       TICK_CYCLES  = TICK_CYCLES_DEF,
    parameter logic [8*16-1:0]   WDOG_PERIODS = {16'd1600, 16'd800, 16'd400, 16'd200,
                                                 16'd100, 16'd50, 16'd20, 16'd10}
)
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Mode and supply
    input  wire logic        i_enable_a,
    input  wire logic        i_enable_b,
    input  wire logic        i_vin_good,
    output frws_seq_t        o_seq_mode,
    // Switcher
    input  wire logic        i_sw_peak_limit,
    input  wire logic        i_sw_valley,
    output logic             o_sw_enable,
    output logic             o_sw_high_side_off,
    output logic             o_sw_soft_start,
    output logic             o_sw_osc_clk,
    // Oscillator trim and clock sync pin
    input  wire logic        i_frequency_trim_open,
    input  wire logic [6:0]  i_frequency_trim_half,
    input  wire logic        i_clock_source_select,
    input  wire logic        i_clock_sync_pin,
    output logic             o_clock_sync_pin,
    output logic             o_clock_sync_pin_oe,
    // Linear regulator
    input  wire logic        i_ldo_sense_oc,
    input  wire logic        i_ldo_sense_on_boost,
    input  wire logic        i_ldo_driver_saturated,
    output logic             o_ldo_enable,
    // Thermal and pull-downs
    input  wire logic        i_over_temp,
    input  wire logic        i_core_pulldown_hot,
    input  wire logic        i_linear_pulldown_hot,
    input  wire logic        i_core_pulldown_req,
    input  wire logic        i_linear_pulldown_req,
    output logic             o_core_output_pulldown,
    output logic             o_linear_output_pulldown,
    // Reset output and reset delay timer
    input  wire logic        i_core_out_of_reg,
    input  wire logic        i_ldo_out_of_reg,
    input  wire logic        i_reset_delay_timer_pin,
    output logic             o_reset_delay_timer_discharge,
    output logic             o_rst_n_out,
    output logic             o_rst_n_oe
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic frws_seq_t frws_decode(input logic a, input logic b);
        frws_decode = frws_seq_t'({a, b});
    endfunction

    function automatic logic [15:0] frws_period(input logic [2:0] sel);
        frws_period = WDOG_PERIODS[16*sel +: 16];
    endfunction

    // ----------------------------------------------------------------
    // Timebase
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt;
    logic        tick;
    wire  logic  tick_wrap = (tick_cnt == 16'(TICK_CYCLES - 1));

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_wrap ? 16'h0000 : tick_cnt + 16'd1;
            tick     <= tick_wrap;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode and regulator retry units
    // ----------------------------------------------------------------
    wire frws_seq_t mode  = frws_decode(i_enable_a, i_enable_b);
    wire logic      reg_on = i_vin_good && (mode != FRWS_SEQ_OFF) && !i_over_temp;
    wire logic      ldo_oc = i_ldo_sense_on_boost ? i_ldo_driver_saturated
                                                  : i_ldo_sense_oc;

    frws_retry_if sw_if();
    frws_retry_if ldo_if();

    assign sw_if.tick  = tick;
    assign sw_if.en    = reg_on;
    assign sw_if.oc    = i_sw_peak_limit;
    assign ldo_if.tick = tick;
    assign ldo_if.en   = reg_on;
    assign ldo_if.oc   = ldo_oc;

    frws_retry u_sw_retry (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .rif       (sw_if.unit)
    );

    frws_retry u_ldo_retry (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .rif       (ldo_if.unit)
    );

    assign o_sw_enable     = sw_if.run;
    assign o_sw_soft_start = sw_if.soft_start;
    assign o_ldo_enable    = ldo_if.run;

    // ----------------------------------------------------------------
    // High side cycle limit
    // ----------------------------------------------------------------
    wire logic next_hs_off = i_sw_peak_limit || (o_sw_high_side_off && !i_sw_valley);

    // ----------------------------------------------------------------
    // Oscillator and clock sync pin
    // ----------------------------------------------------------------
    logic [6:0] osc_cnt;
    logic       sync_prev;
    wire  logic [6:0] trim_half = (i_frequency_trim_half < OSC_HALF_MIN) ? OSC_HALF_MIN :
                                  (i_frequency_trim_half > OSC_HALF_MAX) ? OSC_HALF_MAX :
                                  i_frequency_trim_half;
    wire  logic [6:0] osc_half  = i_frequency_trim_open ? OSC_HALF_DEF : trim_half;
    wire  logic sync_input = !i_clock_source_select;
    wire  logic sync_edge  = sync_input && i_clock_sync_pin && !sync_prev
                             && !sw_if.limited;
    wire  logic osc_wrap   = (osc_cnt + 7'd1 >= osc_half);
    wire  logic next_osc   = sync_edge ? 1'b1 : (osc_wrap ? !o_sw_osc_clk : o_sw_osc_clk);
    wire  logic [6:0] next_osc_cnt = (sync_edge || osc_wrap) ? 7'h00 : osc_cnt + 7'd1;

    // ----------------------------------------------------------------
    // Regulation deglitch
    // ----------------------------------------------------------------
    logic [8:0] dg_cnt;
    logic       fault_filt;
    wire  logic out_of_reg = i_core_out_of_reg || i_ldo_out_of_reg;
    wire  logic dg_full    = (dg_cnt + 9'd1 >= DEGLITCH_CYCLES);

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    logic [7:0]  wd_cmd;
    logic        wd_active;
    logic [15:0] wd_cnt;
    logic        wd_expire;
    wire  logic [15:0] wd_len  = frws_period(wd_cmd[CMD_SEL_LSB +: CMD_SEL_W]);
    wire  logic        wd_open = !wd_cmd[CMD_WINDOW_BIT] || (wd_cnt >= (wd_len >> 1));
    wire  logic        wd_end  = wd_active && tick && (wd_cnt + 16'd1 >= wd_len);

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic       bus_ack;
    wire  logic bus_req  = i_avs_read || i_avs_write;
    wire  logic cmd_hit  = (i_avs_address == REG_WDOG_CMD);
    wire  logic stat_hit = (i_avs_address == REG_STATUS);
    wire  logic cmd_wr   = bus_ack && i_avs_write && cmd_hit;
    wire  logic cmd_take = cmd_wr && (!wd_active || !wd_cmd[CMD_WINDOW_BIT] || wd_open);
    wire  logic [7:0]  next_cmd = cmd_take ? i_avs_writedata[7:0] : wd_cmd;
    wire  logic [31:0] status = {22'h0, o_seq_mode, i_over_temp, ldo_if.limited,
                                 ldo_if.run, sw_if.limited, sw_if.run,
                                 wd_active && wd_open, wd_active, o_rst_n_out};
    wire  logic [31:0] rd_mux = cmd_hit  ? {24'h000000, wd_cmd} :
                                stat_hit ? status : 32'h00000000;

    // ----------------------------------------------------------------
    // Reset control
    // ----------------------------------------------------------------
    frws_rst_t  rs_state;
    logic [7:0] rs_cnt;
    wire  logic rs_trigger = !i_vin_good || (mode == FRWS_SEQ_OFF) || fault_filt
                             || wd_expire || !sw_if.run || !ldo_if.run;
    wire  logic rs_done    = (rs_cnt >= RESET_TICKS) && i_reset_delay_timer_pin;
    wire  frws_rst_t next_rs = rs_trigger ? FRWS_RS_HOLD :
                               (rs_done ? FRWS_RS_RELEASED : rs_state);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sw_high_side_off <= 1'b1;
            o_sw_osc_clk       <= 1'b0;
            o_clock_sync_pin   <= 1'b1;
            o_clock_sync_pin_oe <= 1'b0;
            osc_cnt            <= 7'h00;
            sync_prev          <= 1'b0;
            o_seq_mode         <= FRWS_SEQ_OFF;
            o_core_output_pulldown   <= 1'b0;
            o_linear_output_pulldown <= 1'b0;
        end
        else
        begin
            o_sw_high_side_off <= next_hs_off || !sw_if.run;
            o_sw_osc_clk       <= next_osc;
            o_clock_sync_pin   <= !next_osc;
            o_clock_sync_pin_oe <= i_clock_source_select;
            osc_cnt            <= next_osc_cnt;
            sync_prev          <= i_clock_sync_pin;
            o_seq_mode         <= mode;
            o_core_output_pulldown   <= i_core_pulldown_req && !i_core_pulldown_hot;
            o_linear_output_pulldown <= i_linear_pulldown_req && !i_linear_pulldown_hot;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dg_cnt     <= 9'h000;
            fault_filt <= 1'b0;
        end
        else
        begin
            dg_cnt     <= (!out_of_reg || dg_full) ? 9'h000 : dg_cnt + 9'd1;
            fault_filt <= out_of_reg && (fault_filt || dg_full);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wd_cmd    <= CMD_RESET;
            wd_active <= 1'b0;
            wd_cnt    <= 16'h0000;
            wd_expire <= 1'b0;
        end
        else
        begin
            wd_cmd    <= next_cmd;
            wd_active <= cmd_take || (wd_active && !wd_end);
            wd_cnt    <= (cmd_take || wd_end) ? 16'h0000 :
                         ((wd_active && tick) ? wd_cnt + 16'd1 : wd_cnt);
            wd_expire <= wd_end && !cmd_take;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rs_state    <= FRWS_RS_HOLD;
            rs_cnt      <= 8'h00;
            o_rst_n_out <= 1'b0;
            o_rst_n_oe  <= 1'b1;
            o_reset_delay_timer_discharge <= 1'b1;
        end
        else
        begin
            rs_state    <= next_rs;
            rs_cnt      <= rs_trigger ? 8'h00 :
                           ((tick && rs_cnt < RESET_TICKS) ? rs_cnt + 8'd1 : rs_cnt);
            o_rst_n_out <= 1'b0;
            o_rst_n_oe  <= (next_rs == FRWS_RS_HOLD);
            o_reset_delay_timer_discharge <= rs_trigger;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bus_ack           <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h00000000;
        end
        else
        begin
            bus_ack           <= bus_req && !bus_ack;
            o_avs_waitrequest <= !(bus_req && !bus_ack);
            o_avs_readdata    <= (i_avs_read && !bus_ack) ? rd_mux : o_avs_readdata;
        end
    end
endmodule

// ===== tb/frws_checker.sv
// Purpose: Port assertions for the supervisor
// Assumes: One clock, asynchronous active-low reset
// Notes:   Attached by the bind at the foot
module frws_checker
    import frws_pkg::*;
(
    // Clock, reset, bus, mode
    input wire logic i_ref_clk, i_rst_n, o_avs_waitrequest, i_enable_a, i_enable_b,
    input wire logic i_vin_good, i_over_temp, o_rst_n_oe,
    input wire frws_pkg::frws_seq_t o_seq_mode,
    // Regulators and oscillator
    input wire logic i_sw_peak_limit, o_sw_enable, o_sw_high_side_off, o_sw_soft_start,
    input wire logic o_sw_osc_clk, i_clock_source_select, o_clock_sync_pin,
    input wire logic o_clock_sync_pin_oe, o_ldo_enable,
    // Pull-downs
    input wire logic i_core_pulldown_hot, i_linear_pulldown_hot,
    input wire logic o_core_output_pulldown, o_linear_output_pulldown
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_hot; i_over_temp ##1 i_over_temp; endsequence
    sequence s_ack; !o_avs_waitrequest; endsequence
    property p_therm; s_hot |=> !o_sw_enable && !o_ldo_enable; endproperty
    property p_pdc; i_core_pulldown_hot |=> !o_core_output_pulldown; endproperty
    property p_pdl; i_linear_pulldown_hot |=> !o_linear_output_pulldown; endproperty
    property p_hs; i_sw_peak_limit |=> o_sw_high_side_off; endproperty
    property p_inv; o_clock_sync_pin != o_sw_osc_clk; endproperty
    property p_oe; $past(i_rst_n) |-> o_clock_sync_pin_oe == $past(i_clock_source_select);
    endproperty
    property p_seq; $past(i_rst_n) |-> o_seq_mode == $past({i_enable_a, i_enable_b});
    endproperty
    property p_ack; s_ack |=> o_avs_waitrequest; endproperty
    property p_ss; o_sw_soft_start |=> !o_sw_soft_start; endproperty
    property p_vin; !i_vin_good |-> ##[1:2] o_rst_n_oe; endproperty
    a_therm: assert property (p_therm) else $error("regulator on while hot");
    a_pdc: assert property (p_pdc) else $error("core pull-down on while hot");
    a_pdl: assert property (p_pdl) else $error("linear pull-down on while hot");
    a_hs: assert property (p_hs) else $error("high side on at peak");
    a_inv: assert property (p_inv) else $error("sync output not inverted");
    a_oe: assert property (p_oe) else $error("sync pin direction wrong");
    a_seq: assert property (p_seq) else $error("enable decode wrong");
    a_ack: assert property (p_ack) else $error("waitrequest low too long");
    a_ss: assert property (p_ss) else $error("soft start pulse too long");
    a_vin: assert property (p_vin) else $error("no reset on supply loss");
endmodule
bind frws_supervisor frws_checker u_chk (.*);

// ===== tb/frws_host.sv
// Purpose: Host model issuing watchdog commands on the register bus
// Assumes: Avalon-MM slave with waitrequest
// Notes:   Released write data is inverted so stale data is never reused
module frws_host (
    // Clock and answer
    input  wire logic        i_ref_clk,
    input  wire logic        i_wait,
    input  wire logic [31:0] i_rdata,
    // Request
    output logic      [3:0]  o_addr,
    output logic             o_rd,
    output logic             o_wr,
    output logic      [31:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_addr = 4'h0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= wr;
        o_rd <= !wr;
        do @(posedge i_ref_clk); while (i_wait);
        q = i_rdata;
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
endmodule

// ===== tb/fault_retry_watchdog_supervisor_test.sv
// Purpose: Self-checking bench for the supervisor
// Assumes: Timebase shortened to 20 cycles a tick
// Notes:   Timings are checked to within one tick, the reset hold time only as a minimum
module fault_retry_watchdog_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    import frws_pkg::*;
    localparam int TK = 20;
    logic i_ref_clk, i_rst_n, i_avs_read, i_avs_write, i_enable_a, i_enable_b, i_vin_good;
    logic i_sw_peak_limit, i_sw_valley, i_frequency_trim_open, i_clock_source_select;
    logic i_clock_sync_pin, i_ldo_sense_oc, i_ldo_sense_on_boost, i_ldo_driver_saturated;
    logic i_over_temp, i_core_pulldown_hot, i_linear_pulldown_hot, i_core_pulldown_req;
    logic i_linear_pulldown_req, i_core_out_of_reg, i_ldo_out_of_reg, i_reset_delay_timer_pin;
    logic o_avs_waitrequest, o_sw_enable, o_sw_high_side_off, o_sw_soft_start, o_sw_osc_clk;
    logic o_clock_sync_pin, o_clock_sync_pin_oe, o_ldo_enable, o_core_output_pulldown;
    logic o_linear_output_pulldown, o_reset_delay_timer_discharge, o_rst_n_out, o_rst_n_oe;
    logic [3:0] i_avs_address;
    logic [6:0] i_frequency_trim_half;
    logic [31:0] i_avs_writedata, o_avs_readdata, q;
    frws_seq_t o_seq_mode;
    int err_count, n_compared, cyc, t, i;
    int seed = 32'h1bf7;
    frws_supervisor #(.TICK_CYCLES(TK)) DUT (.*);
    frws_host host (.i_ref_clk(i_ref_clk), .i_wait(o_avs_waitrequest), .i_rdata(o_avs_readdata),
        .o_addr(i_avs_address), .o_rd(i_avs_read), .o_wr(i_avs_write), .o_wdata(i_avs_writedata));
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return o_rst_n_oe;
            1: return o_sw_enable;
            2: return o_ldo_enable;
            default: return o_sw_osc_clk;
        endcase
    endfunction
    task automatic waitv(input int k, input logic v);
        @(negedge i_ref_clk);
        while (sig(k) !== v) @(negedge i_ref_clk);
    endtask
    function automatic logic near(input int n, input int e);
        return n >= e - TK && n <= e + TK;
    endfunction
    function automatic logic [1:0] pd();
        return {i_core_pulldown_req & ~i_core_pulldown_hot,
                i_linear_pulldown_req & ~i_linear_pulldown_hot};
    endfunction
    task automatic oc(input int k);
        @(posedge i_ref_clk);
        {i_sw_peak_limit, i_ldo_driver_saturated} <= (k == 1) ? 2'b10 : 2'b01;
        t = cyc;
        waitv(k, 1'b0);
        chk(near(cyc - t, 10 * TK), 1'b1);
        t = cyc;
        waitv(k, 1'b1);
        chk(near(cyc - t, 100 * TK), 1'b1);
        t = cyc;
        waitv(k, 1'b0);
        chk(near(cyc - t, 10 * TK), 1'b1);
        @(posedge i_ref_clk);
        {i_sw_peak_limit, i_ldo_driver_saturated} <= 2'b00;
        waitv(k, 1'b1);
    endtask
    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_count++;
            conclude();
        end
    end
    always
    begin
        repeat (30) @(posedge i_ref_clk);
        i_clock_sync_pin <= ~i_clock_sync_pin;
    end
    initial
    begin
        {i_rst_n, i_enable_a, i_enable_b, i_vin_good, i_sw_peak_limit, i_sw_valley} = 6'h1c;
        {i_frequency_trim_open, i_clock_source_select, i_clock_sync_pin, i_ldo_sense_oc} = 4'hc;
        {i_ldo_sense_on_boost, i_ldo_driver_saturated, i_over_temp, i_core_pulldown_hot} = 4'h0;
        {i_linear_pulldown_hot, i_core_pulldown_req, i_linear_pulldown_req} = 3'h0;
        {i_core_out_of_reg, i_ldo_out_of_reg, i_reset_delay_timer_pin} = 3'h1;
        i_frequency_trim_half = 7'h21;
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        waitv(0, 1'b0);
        chk({o_sw_enable, o_ldo_enable, o_reset_delay_timer_discharge}, 3'b110);
        host.xfer(1'b0, 4'h4, 32'h0, q);
        chk(q[9:0], 10'h328);
        host.xfer(1'b0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
        i = {$random(seed)} % 3;
        host.xfer(1'b1, 4'h0, i, q);
        repeat (i * 5 * TK) @(posedge i_ref_clk);
        host.xfer(1'b1, 4'h0, i, q);
        t = cyc;
        waitv(0, 1'b1);
        chk(near(cyc - t, (i == 2 ? 50 : 10 + 10 * i) * TK), 1'b1);
        t = cyc;
        waitv(0, 1'b0);
        chk(cyc - t >= 10 * TK, 1'b1);
        host.xfer(1'b0, 4'h4, 32'h0, q);
        chk(q[1], 1'b0);
        host.xfer(1'b1, 4'h0, 32'h80, q);
        t = cyc;
        repeat (2 * TK) @(posedge i_ref_clk);
        host.xfer(1'b1, 4'h0, 32'h80, q);
        waitv(0, 1'b1);
        chk(near(cyc - t, 10 * TK), 1'b1);
        waitv(0, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            @(posedge i_ref_clk);
            i_frequency_trim_open <= (i == 0);
            i_frequency_trim_half <= 7'd25 + 7'({$random(seed)} % 26);
            waitv(3, 1'b1);
            waitv(3, 1'b0);
            t = cyc;
            waitv(3, 1'b1);
            chk(cyc - t, i ? 32'(i_frequency_trim_half) : 32'(OSC_HALF_DEF));
        end
        @(posedge i_ref_clk);
        i_clock_source_select <= 1'b0;
        repeat (40) @(posedge i_ref_clk);
        chk(o_clock_sync_pin_oe, 1'b0);
        i_clock_source_select <= 1'b1;
        repeat (20)
        begin
            @(posedge i_ref_clk);
            {i_core_pulldown_req, i_core_pulldown_hot, i_linear_pulldown_req,
             i_linear_pulldown_hot, i_sw_valley, i_core_out_of_reg} <= 6'($random(seed));
            repeat (2) @(posedge i_ref_clk);
            chk({o_sw_enable, o_ldo_enable, o_rst_n_oe, o_core_output_pulldown,
                 o_linear_output_pulldown}, {3'b110, pd()});
        end
        {i_over_temp, i_core_out_of_reg} <= 2'b10;
        repeat (3) @(posedge i_ref_clk);
        chk({o_sw_enable, o_ldo_enable}, 2'b00);
        i_over_temp <= 1'b0;
        waitv(1, 1'b1);
        @(posedge i_ref_clk);
        i_vin_good <= 1'b0;
        i_ldo_sense_on_boost <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_vin_good <= 1'b1;
        oc(1);
        oc(2);
        for (i = 0; i < 4; i++)
        begin
            @(posedge i_ref_clk);
            {i_enable_a, i_enable_b} <= 2'(i);
            repeat (3) @(posedge i_ref_clk);
            chk(o_seq_mode, i);
        end
        conclude();
    end
endmodule
